//--- rtl/fnsd_cfg.svh
// Purpose: constants for the fieldbus node switch decoder
// Assumes: 20 MHz ref_clk
// Notes: switch positions are one based (position one is bit 0)
`ifndef FNSD_CFG_SVH
`define FNSD_CFG_SVH
// ----------------------------------------------------------------
// switch field positions
// ----------------------------------------------------------------
`define FNSD_B1_SIZE_P1 0
`define FNSD_B1_SIZE_P2 1
`define FNSD_B1_RATE_P3 2
`define FNSD_B1_RATE_P4 3
`define FNSD_B2_HOLD_P4 3
`define FNSD_B2_HUND_P8 7
// ----------------------------------------------------------------
// address limits and sizes
// ----------------------------------------------------------------
`define FNSD_ADDR_MIN 9'h001
`define FNSD_ADDR_MAX 9'h07E
`define FNSD_DIGIT_MAX 4'h9
`define FNSD_HUND_WT 9'h064
`define FNSD_TENS_WT 9'h00A
`define FNSD_BYTES_FULL 3'h4
`define FNSD_LEN_IDLE 3'h0
// ----------------------------------------------------------------
// register offsets (byte addresses) and bits
// ----------------------------------------------------------------
`define FNSD_REG_CTRL 4'h0
`define FNSD_REG_STATUS 4'h4
`define FNSD_REG_IRQ_STAT 4'h8
`define FNSD_REG_IRQ_MASK 4'hC
`define FNSD_CTRL_HOLD_EN 0
`define FNSD_IRQ_W 3
`define FNSD_IRQ_CFG_ERR 0
`define FNSD_IRQ_COMM_ERR 1
`define FNSD_IRQ_IDLE 2
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FNSD_CLK_HZ 20000000
`define FNSD_FLASH_HALF_MS 500
`define FNSD_SETTLE_CYC 4'h4
`endif

//--- rtl/fnsd_pkg.sv
// Purpose: shared types of the fieldbus node switch decoder
// Assumes: constants live in fnsd_cfg.svh
// Notes: none
package fnsd_pkg;
  // raw setting switch inputs
  typedef struct packed {
    logic [7:0] bank_one; // switch_bank_one positions 8..1
    logic [7:0] bank_two; // switch_bank_two positions 8..1
    logic [3:0] tens;     // tens rotary digit
    logic [3:0] units;    // units rotary digit
  } fnsd_switch_t;
  // internal unit-to-unit link rate
  typedef enum logic [1:0] {RATE_1M, RATE_500K, RATE_250K, RATE_125K} fnsd_rate_t;
  // decoded configuration
  typedef struct packed {
    logic [8:0] node_addr;
    logic [2:0] out_bytes;
    fnsd_rate_t link_rate;
    logic hold_switch;
  } fnsd_conf_t;
  // output data packet from the fieldbus engine
  typedef struct packed {
    logic valid;
    logic [2:0] len;
    logic [31:0] data;
  } fnsd_pkt_t;
  // start-up sampling sequence
  typedef enum logic [1:0] {ST_SETTLE, ST_LATCH, ST_RUN} fnsd_state_t;
endpackage : fnsd_pkg

//--- rtl/fnsd_sync.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: synchronous active high reset
// Notes: only stage two is visible outside
`timescale 1ns/1ps
`default_nettype none
module fnsd_sync #(
  parameter int W = 24
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage1; // first stage, read by stage two only
  // two stage capture
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule : fnsd_sync
`default_nettype wire

//--- rtl/fnsd_flasher.sv
// Purpose: square wave for flashing fault indicators
// Assumes: HALF is the half period in clock cycles
// Notes: phase restarts while en is low
`timescale 1ns/1ps
`default_nettype none
module fnsd_flasher #(
  parameter int HALF = 10000000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic en,
  output logic blink
);
  localparam int CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  logic [CW-1:0] cnt; // cycles in current half period
  // count half periods, toggle at each end
  always_ff @(posedge ref_clk) begin
    if (rst || !en) begin
      cnt <= '0;
      blink <= 1'b0;
    end else if (cnt == LAST) begin
      cnt <= '0;
      blink <= ~blink;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule : fnsd_flasher
`default_nettype wire

//--- rtl/fnsd_top.sv
// Purpose: decode setting switches into node configuration and apply output policy
// Assumes: switches are pins; packets and comm error come from same-clock logic
// Notes: registers on classic Wishbone, 32-bit words
//
// Functional notes
// - address is hundreds switch plus two rotaries
// - address zero or above 126 flashes faults
// - all switches off give factory defaults
// - bank one positions 1-2 select output bytes
// - bank one positions 3-4 select link rate
// - on error, clear or hold per switch
// - hold switch used only when parameter enables
// - zero length packet means idle, safe action
`timescale 1ns/1ps
`default_nettype none
`include "fnsd_cfg.svh"
module fnsd_top #(
  parameter int FLASH_HALF_CYC = `FNSD_FLASH_HALF_MS * (`FNSD_CLK_HZ / 1000)
) (
  input wire logic ref_clk,
  input wire logic rst,
  // setting switches, asynchronous pins
  input wire fnsd_pkg::fnsd_switch_t switch_pins,
  // fieldbus engine side
  input wire fnsd_pkg::fnsd_pkt_t out_pkt,
  input wire logic comm_err,
  // decoded configuration
  output fnsd_pkg::fnsd_conf_t conf,
  output logic cfg_loaded,
  output logic cfg_error,
  output logic [31:0] valve_out,
  output logic system_fault_indicator,
  output logic bus_fault_indicator,
  output logic irq,
  // classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import fnsd_pkg::*;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // node address from hundreds switch and rotaries
  function automatic logic [8:0] addr_of(input fnsd_switch_t s);
    logic [8:0] h;
    // hundreds switch adds a fixed weight; the tens digit is scaled
    h = s.bank_two[`FNSD_B2_HUND_P8] ? `FNSD_HUND_WT : 9'h000;
    return h + 9'(s.tens) * `FNSD_TENS_WT + 9'(s.units);
  endfunction : addr_of

  // output byte count from the size pair
  function automatic logic [2:0] bytes_of(input fnsd_switch_t s);
    return `FNSD_BYTES_FULL - {1'b0, s.bank_one[`FNSD_B1_SIZE_P1],
                               s.bank_one[`FNSD_B1_SIZE_P2]};
  endfunction : bytes_of

  // link rate from the rate pair
  function automatic fnsd_rate_t rate_of(input fnsd_switch_t s);
    return fnsd_rate_t'({s.bank_one[`FNSD_B1_RATE_P3], s.bank_one[`FNSD_B1_RATE_P4]});
  endfunction : rate_of

  // byte mask for the active output size
  function automatic logic [31:0] mask_of(input logic [2:0] n);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(n)) m[i*8 +: 8] = 8'hFF;
    end
    return m;
  endfunction : mask_of

  // ----------------------------------------------------------------
  // switch synchroniser and start-up latch
  // ----------------------------------------------------------------
  fnsd_switch_t sw_sync; // switches after two flops
  fnsd_state_t state; // start-up sequence state
  logic [3:0] settle; // settle count after reset
  logic [2:0] irq_stat; // sticky event bits
  logic [2:0] irq_mask; // event enables
  logic [2:0] irq_evt; // one-cycle events
  logic ctrl_hold_en; // parameter enabling the hold switch
  logic hold_eff; // effective hold action
  logic idle_state; // master in clear mode
  logic comm_err_q; // previous comm error level
  logic blink; // flash phase
  logic rd_stat; // read of the interrupt status register this cycle
  logic wb_hit; // new bus request
  logic [8:0] dec_addr; // address from synchronised switches

  fnsd_sync #(.W($bits(fnsd_switch_t))) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(switch_pins),
    .q(sw_sync)
  );

  assign dec_addr = addr_of(sw_sync);

  // settle, latch once, then run until the next reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_SETTLE;
      settle <= 4'h0;
    end else begin
      case (state)
        ST_SETTLE: begin
          settle <= settle + 4'h1;
          if (settle == `FNSD_SETTLE_CYC) state <= ST_LATCH;
        end
        ST_LATCH: state <= ST_RUN;
        ST_RUN: state <= ST_RUN;
        default: state <= ST_SETTLE;
      endcase
    end
  end

  // decoded configuration, defaults match all switches off
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conf.node_addr <= 9'h000;
      conf.out_bytes <= `FNSD_BYTES_FULL;
      conf.link_rate <= RATE_1M;
      conf.hold_switch <= 1'b0;
      cfg_loaded <= 1'b0;
      cfg_error <= 1'b0;
    end else if (state == ST_LATCH) begin
      conf.node_addr <= dec_addr;
      conf.out_bytes <= bytes_of(sw_sync);
      conf.link_rate <= rate_of(sw_sync);
      conf.hold_switch <= sw_sync.bank_two[`FNSD_B2_HOLD_P4];
      cfg_loaded <= 1'b1;
      // out of range, or a rotary past nine
      cfg_error <= (dec_addr < `FNSD_ADDR_MIN) || (dec_addr > `FNSD_ADDR_MAX) ||
                   (sw_sync.tens > `FNSD_DIGIT_MAX) ||
                   (sw_sync.units > `FNSD_DIGIT_MAX);
    end
  end

  // ----------------------------------------------------------------
  // fault indicators
  // ----------------------------------------------------------------
  fnsd_flasher #(.HALF(FLASH_HALF_CYC)) u_flash (
    .ref_clk(ref_clk),
    .rst(rst),
    .en(cfg_error),
    .blink(blink)
  );

  // both flash together on a bad address; bus fault lit on comm error
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      system_fault_indicator <= 1'b0;
      bus_fault_indicator <= 1'b0;
    end else if (cfg_error) begin
      system_fault_indicator <= blink;
      bus_fault_indicator <= blink;
    end else begin
      system_fault_indicator <= 1'b0;
      bus_fault_indicator <= comm_err;
    end
  end

  // ----------------------------------------------------------------
  // output policy
  // ----------------------------------------------------------------
  assign hold_eff = ctrl_hold_en & conf.hold_switch;

  // zero length packet enters idle, any data packet leaves it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idle_state <= 1'b0;
    end else if (out_pkt.valid) begin
      idle_state <= (out_pkt.len == `FNSD_LEN_IDLE);
    end
  end

  // valve outputs: data masked to size, or safe action
  always_ff @(posedge ref_clk) begin
    if (rst || !cfg_loaded || cfg_error) begin
      valve_out <= 32'h0000_0000;
    end else if (comm_err || idle_state) begin
      if (!hold_eff) valve_out <= 32'h0000_0000;
    end else if (out_pkt.valid && out_pkt.len != `FNSD_LEN_IDLE) begin
      valve_out <= out_pkt.data & mask_of(conf.out_bytes);
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) comm_err_q <= 1'b0;
    else comm_err_q <= comm_err;
  end

  // one-cycle event sources feeding the sticky bits
  assign irq_evt[`FNSD_IRQ_CFG_ERR] = (state == ST_LATCH) &&
      ((dec_addr < `FNSD_ADDR_MIN) || (dec_addr > `FNSD_ADDR_MAX));
  assign irq_evt[`FNSD_IRQ_COMM_ERR] = comm_err & ~comm_err_q;
  assign irq_evt[`FNSD_IRQ_IDLE] = out_pkt.valid && out_pkt.len == `FNSD_LEN_IDLE;

  // sticky bits; a read clears, a new event in that cycle wins
  always_ff @(posedge ref_clk) begin
    if (rst) irq_stat <= 3'h0;
    else irq_stat <= (rd_stat ? 3'h0 : irq_stat) | irq_evt;
  end

  // level interrupt while an unmasked bit is set
  always_ff @(posedge ref_clk) begin
    if (rst) irq <= 1'b0;
    else irq <= |(((rd_stat ? 3'h0 : irq_stat) | irq_evt) & irq_mask);
  end

  // ----------------------------------------------------------------
  // Wishbone slave, one wait state, ack for one cycle
  // ----------------------------------------------------------------
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_stat = wb_hit && !wb_we_i && (wb_adr_i == `FNSD_REG_IRQ_STAT);

  always_ff @(posedge ref_clk) begin
    if (rst) wb_ack_o <= 1'b0;
    else wb_ack_o <= wb_hit;
  end

  // writable registers, low byte lane carries the bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_hold_en <= 1'b0;
      irq_mask <= 3'h0;
    end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        `FNSD_REG_CTRL: ctrl_hold_en <= wb_dat_i[`FNSD_CTRL_HOLD_EN];
        `FNSD_REG_IRQ_MASK: irq_mask <= wb_dat_i[`FNSD_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // read data; unmapped offsets read zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_hit && !wb_we_i) begin
      case (wb_adr_i)
        `FNSD_REG_CTRL: wb_dat_o <= {31'h0, ctrl_hold_en};
        `FNSD_REG_STATUS: wb_dat_o <= {13'h0, idle_state, hold_eff, cfg_loaded,
                                       cfg_error, conf.link_rate, conf.out_bytes,
                                       conf.hold_switch, conf.node_addr};
        `FNSD_REG_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat};
        `FNSD_REG_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_addr;
    @(posedge ref_clk) disable iff (rst)
      $rose(cfg_loaded) |-> conf.node_addr == $past(dec_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("node address mismatch");

  property p_err;
    @(posedge ref_clk) disable iff (rst)
      $rose(cfg_loaded) &&
      (conf.node_addr < `FNSD_ADDR_MIN || conf.node_addr > `FNSD_ADDR_MAX)
      |-> cfg_error;
  endproperty
  a_err: assert property (p_err) else $error("bad address not flagged");

  property p_flash;
    @(posedge ref_clk) disable iff (rst)
      cfg_error |=> system_fault_indicator == bus_fault_indicator;
  endproperty
  a_flash: assert property (p_flash) else $error("fault indicators differ");

  property p_dflt;
    @(posedge ref_clk) rst |=> conf.node_addr == 9'h000 &&
      conf.out_bytes == `FNSD_BYTES_FULL &&
      conf.link_rate == RATE_1M && !conf.hold_switch;
  endproperty
  a_dflt: assert property (p_dflt) else $error("reset defaults wrong");

  property p_size;
    @(posedge ref_clk) disable iff (rst)
      $rose(cfg_loaded) |-> conf.out_bytes == bytes_of($past(sw_sync)) &&
      conf.out_bytes != 3'h0;
  endproperty
  a_size: assert property (p_size) else $error("output size mismatch");

  property p_rate;
    @(posedge ref_clk) disable iff (rst)
      $rose(cfg_loaded) |-> conf.link_rate == rate_of($past(sw_sync));
  endproperty
  a_rate: assert property (p_rate) else $error("link rate mismatch");

  property p_clear;
    @(posedge ref_clk) disable iff (rst)
      comm_err && !hold_eff |=> valve_out == 32'h0000_0000;
  endproperty
  a_clear: assert property (p_clear) else $error("outputs not cleared");

  property p_hold;
    @(posedge ref_clk) disable iff (rst)
      cfg_loaded && !cfg_error && comm_err && hold_eff |=> $stable(valve_out);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs not held");

  property p_ign;
    @(posedge ref_clk) disable iff (rst)
      !ctrl_hold_en && conf.hold_switch && comm_err |=> valve_out == 32'h0000_0000;
  endproperty
  a_ign: assert property (p_ign) else $error("hold switch not ignored");

  property p_idle;
    @(posedge ref_clk) disable iff (rst)
      out_pkt.valid && out_pkt.len == `FNSD_LEN_IDLE ##1 !hold_eff && !out_pkt.valid
      |=> valve_out == 32'h0000_0000;
  endproperty
  a_idle: assert property (p_idle) else $error("idle did not clear");

  property p_frz;
    @(posedge ref_clk) disable iff (rst) cfg_loaded |=> $stable(conf);
  endproperty
  a_frz: assert property (p_frz) else $error("config changed after load");

  // main scenarios that the bench should reach
  c_cfg_err: cover property (@(posedge ref_clk) disable iff (rst) $rose(cfg_error));
  c_idle: cover property (@(posedge ref_clk) disable iff (rst) $rose(idle_state));
  c_hold: cover property (@(posedge ref_clk) disable iff (rst) comm_err && hold_eff);
  c_irq: cover property (@(posedge ref_clk) disable iff (rst) irq ##1 rd_stat);
  c_leave: cover property (@(posedge ref_clk) disable iff (rst) $fell(idle_state));
endmodule : fnsd_top
`default_nettype wire

//--- verif/fnsd_master_model.sv
// Purpose: behavioural fieldbus master feeding packets and comm error
// Assumes: shares ref_clk with the decoder
// Notes: data lines carry junk while no packet is offered, the last packet inverted after a send
`timescale 1ns/1ps
`default_nettype none
module fnsd_master_model (
  input wire logic ref_clk,
  output fnsd_pkg::fnsd_pkt_t out_pkt,
  output logic comm_err
);
  import fnsd_pkg::*;
  // ----------------------------------------------------------------
  // idle lines
  // ----------------------------------------------------------------
  initial begin
    out_pkt = '{valid: 1'b0, len: 3'h5, data: 32'h5A5A_C3C3};
    comm_err = 1'b0;
  end
  // offer one packet for one cycle, then release the lines
  task automatic send(input logic [2:0] pkt_len, input logic [31:0] pkt_data);
    @(posedge ref_clk);
    out_pkt <= '{valid: 1'b1, len: pkt_len, data: pkt_data};
    @(posedge ref_clk);
    out_pkt <= '{valid: 1'b0, len: ~pkt_len, data: ~pkt_data};
  endtask : send
  // raise or drop the communication error level
  task automatic set_err(input logic e);
    @(posedge ref_clk);
    comm_err <= e;
  endtask : set_err
endmodule : fnsd_master_model
`default_nettype wire

//--- verif/test_fieldbus_node_switch_decoder.sv
// Purpose: self-checking bench for the switch decoder
// Assumes: flash half period shortened to 4 cycles
// Notes: each switch setting needs its own reset
`timescale 1ns/1ps
`default_nettype none
module test_fieldbus_node_switch_decoder;
  import fnsd_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic ref_clk, rst, cfg_loaded, cfg_error, irq, wb_ack_o;
  logic system_fault_indicator, bus_fault_indicator;
  logic wb_cyc_i, wb_stb_i, wb_we_i;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, valve_out;
  fnsd_switch_t switch_pins;
  fnsd_pkt_t out_pkt;
  fnsd_conf_t conf;
  logic comm_err;
  int mismatches, comparisons;
  fnsd_switch_t cases [4];
  int hi;
  logic ok;
  // ----------------------------------------------------------------
  // clock, design and master model
  // ----------------------------------------------------------------
  always #25 ref_clk = ~ref_clk;
  fnsd_top #(.FLASH_HALF_CYC(4)) dut (.ref_clk(ref_clk), .rst(rst),
    .switch_pins(switch_pins), .out_pkt(out_pkt), .comm_err(comm_err), .conf(conf),
    .cfg_loaded(cfg_loaded), .cfg_error(cfg_error), .valve_out(valve_out),
    .system_fault_indicator(system_fault_indicator),
    .bus_fault_indicator(bus_fault_indicator), .irq(irq), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  fnsd_master_model mdl (.ref_clk(ref_clk), .out_pkt(out_pkt), .comm_err(comm_err));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report(input string m);
    mismatches++;
    $display("Error at %0t: %s", $time, m);
  endtask : report
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // compare one word or flag
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string w);
    comparisons++;
    if (g !== e) report($sformatf("%s got %h want %h", w, g, e));
  endtask : chk_val
  // compare a decoded configuration
  task automatic chk_conf(input fnsd_conf_t g, input fnsd_conf_t e);
    comparisons++;
    if (g !== e) report($sformatf("conf got %h want %h", g, e));
  endtask : chk_conf
  // one classic cycle; held until ack is seen at an edge
  task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    // wait for ack at an edge; only the watchdog ends a hang
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_xfer
  task automatic wb_wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask : wb_wr
  task automatic wb_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0, q);
    chk_val(q, e, "bus read");
  endtask : wb_chk
  // expected decode of a switch setting
  function automatic fnsd_conf_t exp_conf(input fnsd_switch_t s);
    fnsd_conf_t c;
    c.node_addr = 9'(s.bank_two[7]) * 9'h064 + 9'(s.tens) * 9'h00A + 9'(s.units);
    c.out_bytes = 3'h4 - {1'b0, s.bank_one[0], s.bank_one[1]};
    c.link_rate = fnsd_rate_t'({s.bank_one[2], s.bank_one[3]});
    c.hold_switch = s.bank_two[3];
    return c;
  endfunction : exp_conf
  // reset with a setting, check decode, then move switches
  task automatic run_cfg(input fnsd_switch_t s);
    fnsd_conf_t e;
    int n;
    logic err;
    e = exp_conf(s);
    // bad address, or a rotary past nine
    err = (e.node_addr == 9'h000) || (e.node_addr > 9'h07E) || (s.tens > 4'h9) ||
          (s.units > 4'h9);
    switch_pins <= s;
    rst <= 1'b1;
    tick(8);
    rst <= 1'b0;
    n = 0;
    while (cfg_loaded !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 40) report("config never loaded");
    chk_conf(conf, e);
    chk_val(32'(cfg_error), 32'(err), "cfg err");
    switch_pins <= ~s;
    tick(6);
    chk_conf(conf, e);
    $display("test config %h done", s);
  endtask : run_cfg
  // verdict
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    tick(5000);
    report("timeout");
    close_out();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    switch_pins = '0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    mismatches = 0;
    comparisons = 0;
    cases[0] = {8'h09, 8'h80, 4'h2, 4'h6};
    cases[1] = {8'h05, 8'h80, 4'h2, 4'h7};
    cases[2] = {8'h0F, 8'h08, 4'h0, 4'h1};
    cases[3] = {8'h00, 8'h00, 4'hA, 4'h1};
    // factory default: address zero flashes both indicators
    run_cfg('0);
    ok = 1'b1;
    hi = 0;
    repeat (16) begin
      @(posedge ref_clk);
      if (system_fault_indicator !== bus_fault_indicator) ok = 1'b0;
      if (system_fault_indicator === 1'b1) hi++;
    end
    chk_val(32'(ok && hi > 0 && hi < 16), 32'h1, "flash");
    wb_wr(4'hC, 32'h1);
    tick(2);
    chk_val(32'(irq), 32'h1, "cfg irq");
    wb_chk(4'h8, 32'h1);
    mdl.send(3'h4, 32'hFFFF_FFFF);
    tick(3);
    chk_val(valve_out, 32'h0, "refused pkt");
    foreach (cases[i]) run_cfg(cases[i]);
    // address 99, three bytes, hold switch on, recommended rate
    run_cfg({8'h02, 8'h08, 4'h9, 4'h9});
    mdl.send(3'h4, 32'hA5C3_1234);
    tick(3);
    chk_val(valve_out, 32'h00C3_1234, "size mask");
    wb_wr(4'hC, 32'h7);
    mdl.set_err(1'b1);
    tick(3);
    chk_val(valve_out, 32'h0, "clear, switch unused");
    chk_val({30'h0, system_fault_indicator, bus_fault_indicator}, 32'h1, "fault lamps");
    chk_val(32'(irq), 32'h1, "err irq");
    wb_chk(4'h8, 32'h2);
    wb_chk(4'h8, 32'h0);
    tick(2);
    chk_val(32'(irq), 32'h0, "irq cleared");
    mdl.set_err(1'b0);
    mdl.send(3'h3, 32'hFFFF_FFFF);
    tick(3);
    chk_val(valve_out, 32'h00FF_FFFF, "reapply");
    wb_wr(4'h0, 32'h1);
    mdl.set_err(1'b1);
    tick(3);
    chk_val(valve_out, 32'h00FF_FFFF, "hold on error");
    mdl.set_err(1'b0);
    mdl.send(3'h0, 32'h0);
    tick(3);
    chk_val(valve_out, 32'h00FF_FFFF, "hold on idle");
    wb_chk(4'h8, 32'h6);
    mdl.send(3'h4, 32'h0000_0011);
    mdl.send(3'h4, 32'h0000_0022);
    tick(3);
    chk_val(valve_out, 32'h0000_0022, "leave idle");
    wb_wr(4'h0, 32'h0);
    mdl.send(3'h0, 32'h0);
    tick(3);
    chk_val(valve_out, 32'h0, "clear on idle");
    wb_chk(4'h4, 32'h0005_0E63);
    wb_wr(4'h2, 32'hFFFF_FFFF);
    wb_chk(4'h2, 32'h0);
    wb_chk(4'hC, 32'h7);
    wb_chk(4'h0, 32'h0);
    $display("test outputs and registers done");
    close_out();
  end
endmodule : test_fieldbus_node_switch_decoder
`default_nettype wire
